// File: rtl/crc_defs.svh
// Purpose: Named constants for the codec reset control block.
// Assumes: Clock runs at 10 MHz from the internal free-running oscillator.
// Notes:   Times are kept in nanoseconds; cycle counts derive from them.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CRC_CLK_PERIOD_NS 100
`define CRC_EXT_TYP_NS 50000
`define CRC_EXT_MAX_NS 100000
`define CRC_EXT_TYP_CYC ((`CRC_EXT_TYP_NS + `CRC_CLK_PERIOD_NS - 1) / `CRC_CLK_PERIOD_NS)
`define CRC_EXT_MAX_CYC (`CRC_EXT_MAX_NS / `CRC_CLK_PERIOD_NS)
`define CRC_CNT_W 10

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CRC_ADDR_W 6
`define CRC_DATA_W 9
`define CRC_NUM_REGS 64
`define CRC_SW_RESET_TRIGGER_OFS 6'h00
`define CRC_REG_DEFAULT 9'h000

`endif

// File: rtl/crc_pkg.sv
// Purpose: Types shared by the codec reset control block.
// Assumes: crc_defs.svh supplies widths.
// Notes:   Nothing here is imported; users write crc_pkg::name.
`include "crc_defs.svh"

package crc_pkg;

   // Reset sequencer states, Gray coded along hold, extend, run.
   typedef enum logic [1:0] {
      CRC_ST_HOLD = 2'h0,
      CRC_ST_EXTEND = 2'h1,
      CRC_ST_RUN = 2'h3
   } crc_state_e;

   // One register write from the serial control interface.
   typedef struct packed {
      logic valid;
      logic [`CRC_ADDR_W-1:0] addr;
      logic [`CRC_DATA_W-1:0] data;
   } crc_wr_s;

   // One register read request and its answer.
   typedef struct packed {
      logic valid;
      logic [`CRC_ADDR_W-1:0] addr;
   } crc_rd_s;

   typedef struct packed {
      logic valid;
      logic [`CRC_DATA_W-1:0] data;
   } crc_rdata_s;

   // Whole module state.
   typedef struct packed {
      crc_state_e state;
      logic [`CRC_CNT_W-1:0] cnt;
      logic soft_reset;
      logic [`CRC_NUM_REGS-1:0][`CRC_DATA_W-1:0] regs;
      crc_rdata_s rdata;
   } crc_state_s;

endpackage

// File: rtl/crc_codec_reset_control.sv
// Purpose: Power-on reset sequencer and register reset control of the codec.
// Assumes: Supply detector levels and control accesses are synchronous to clk.
// Notes:   clk is the internal free-running oscillator, not the master clock.
`include "crc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module crc_codec_reset_control #(
   parameter int EXT_CYCLES = `CRC_EXT_TYP_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic analog_supply_ok,
   input wire logic core_supply_ok,
   input wire crc_pkg::crc_wr_s wr,
   input wire crc_pkg::crc_rd_s rd,
   output var crc_pkg::crc_rdata_s rdata,
   output logic core_reset,
   output logic soft_reset_active,
   output logic [`CRC_NUM_REGS-1:0][`CRC_DATA_W-1:0] reg_image
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   // The extension must be at least one cycle and stay inside the limit.
   if (EXT_CYCLES < 1 || EXT_CYCLES > `CRC_EXT_MAX_CYC ||
       EXT_CYCLES >= (1 << `CRC_CNT_W)) begin : g_bad_ext
      $error("EXT_CYCLES out of range");
   end

   localparam logic [`CRC_CNT_W-1:0] EXT_LAST = `CRC_CNT_W'(EXT_CYCLES - 1);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   crc_pkg::crc_state_s st;
   crc_pkg::crc_state_s next_st;
   logic supplies_ok;
   logic in_reset;

   assign supplies_ok = analog_supply_ok & core_supply_ok;
   // Reset is live whenever the sequencer has not reached run.
   assign in_reset = (st.state != crc_pkg::CRC_ST_RUN);

   // Next-state logic for the sequencer and the register bank.
   always_comb begin
      next_st = st;
      next_st.rdata.valid = 1'b0;
      case (st.state)
         crc_pkg::CRC_ST_HOLD: begin
            next_st.cnt = '0;
            if (supplies_ok) begin
               next_st.state = crc_pkg::CRC_ST_EXTEND;
            end
         end
         crc_pkg::CRC_ST_EXTEND: begin
            // Counted on the internal oscillator so no master clock is needed.
            if (st.cnt == EXT_LAST) begin
               next_st.state = crc_pkg::CRC_ST_RUN;
            end else begin
               next_st.cnt = st.cnt + `CRC_CNT_W'(1);
            end
         end
         crc_pkg::CRC_ST_RUN: begin
            next_st.cnt = '0;
         end
         default: begin
            next_st.state = crc_pkg::CRC_ST_HOLD;
         end
      endcase
      // A supply drop anywhere restarts from hold, so the count begins anew.
      if (!supplies_ok) begin
         next_st.state = crc_pkg::CRC_ST_HOLD;
         next_st.cnt = '0;
      end

      // A low supply sample clears the bank at once, so that no register still shows
      // its old content once core_reset is up, and a write in that same cycle is lost.
      if (in_reset || !supplies_ok) begin
         // Forced defaults; accesses are dropped without an answer.
         for (int i = 0; i < `CRC_NUM_REGS; i++) begin
            next_st.regs[i] = `CRC_REG_DEFAULT;
         end
         next_st.soft_reset = 1'b0;
      end else begin
         if (wr.valid) begin
            if (wr.addr == `CRC_SW_RESET_TRIGGER_OFS) begin
               // Data value is irrelevant; every register reverts.
               for (int i = 0; i < `CRC_NUM_REGS; i++) begin
                  next_st.regs[i] = `CRC_REG_DEFAULT;
               end
               next_st.soft_reset = 1'b1;
            end else begin
               next_st.regs[wr.addr] = wr.data;
               next_st.soft_reset = 1'b0;
            end
         end
         if (rd.valid) begin
            next_st.rdata.valid = 1'b1;
            // The trigger register is write-only and reads as zero.
            next_st.rdata.data = (rd.addr == `CRC_SW_RESET_TRIGGER_OFS) ?
                                 `CRC_REG_DEFAULT : st.regs[rd.addr];
         end
      end
   end

   // State register; srst starts the oscillator-domain logic in hold and clears the count, soft reset flag, bank and read answer.
   always_ff @(posedge clk) begin
      if (srst) begin
         st.state <= crc_pkg::CRC_ST_HOLD;
         st.cnt <= '0;
         st.soft_reset <= 1'b0;
         st.regs <= '0;
         st.rdata <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // No in-reset flag leaves the block toward the control port.
   assign core_reset = in_reset;
   assign soft_reset_active = st.soft_reset;
   assign rdata = st.rdata;
   assign reg_image = st.regs;

endmodule

`default_nettype wire

// File: testbench/crc_host.sv
// Purpose: Host model on the register port.
// Assumes: Drives 1 ns after clk rises.
// Notes: Idle fields show inverted values.
`timescale 1ns/10ps
`default_nettype none
module crc_host (
   input wire logic clk,
   input wire crc_pkg::crc_rdata_s rdata,
   output var crc_pkg::crc_wr_s wr,
   output var crc_pkg::crc_rd_s rd
);
   // Strobes start low so nothing is taken at power-up.
   initial {wr, rd} = '0;
   // One-cycle write strobe.
   task automatic wr_t(input logic [5:0] a, input logic [8:0] d);
      @(posedge clk) #1 wr = {1'b1, a, d};
      @(posedge clk) #1 wr = {1'b0, ~a, ~d};
   endtask
   // The answer stands for one cycle, so it is taken right away.
   task automatic rd_t(input logic [5:0] a, output logic v, output logic [8:0] d);
      @(posedge clk) #1 rd = {1'b1, a};
      @(posedge clk) #1 rd = {1'b0, ~a};
      v = rdata.valid;
      d = rdata.data;
   endtask
endmodule
`default_nettype wire

// File: testbench/crc_properties.sv
// Purpose: Port checks of the reset control.
// Assumes: One clock; srst stops all checks.
// Notes: Bound to the design after the module.
`timescale 1ns/10ps
`default_nettype none
module crc_properties #(parameter int EXT_CYCLES = 4) (
   input wire logic clk,
   input wire logic srst,
   input wire logic analog_supply_ok,
   input wire logic core_supply_ok,
   input wire crc_pkg::crc_wr_s wr,
   input wire crc_pkg::crc_rd_s rd,
   input wire crc_pkg::crc_rdata_s rdata,
   input wire logic core_reset,
   input wire logic soft_reset_active,
   input wire logic [63:0][8:0] reg_image
);
   wire logic ok = analog_supply_ok && core_supply_ok;
   int ok_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Run of good supply samples; capped so it never wraps.
   always_ff @(posedge clk) begin
      ok_cnt <= (srst || !ok) ? 0 : ok_cnt + (ok_cnt <= EXT_CYCLES + 1);
   end
   sequence wr_s;
      !core_reset && ok && wr.valid;
   endsequence
   low_hold_a: assert property (!ok |=> core_reset)
      else $error("reset not held");
   low_clear_a: assert property (!ok |=> reg_image == '0)
      else $error("registers kept");
   ext_len_a: assert property ($fell(core_reset) |-> ok_cnt == EXT_CYCLES + 1)
      else $error("extension length");
   ext_max_a: assert property (ok_cnt > EXT_CYCLES |-> !core_reset)
      else $error("extension too long");
   rd_drop_a: assert property (core_reset && rd.valid |=> !rdata.valid)
      else $error("read in reset");
   wr_drop_a: assert property (core_reset && wr.valid |=> $stable(reg_image))
      else $error("write in reset");
   wr_keep_a: assert property (wr_s ##0 wr.addr != 0 |=>
      reg_image[$past(wr.addr)] == $past(wr.data) && !soft_reset_active) else $error("write lost");
   sw_reset_a: assert property (wr_s ##0 wr.addr == 0 |=> reg_image == '0 && soft_reset_active)
      else $error("soft reset");
endmodule
bind crc_codec_reset_control crc_properties #(.EXT_CYCLES(EXT_CYCLES)) crc_properties_i (.*);
`default_nettype wire

// File: testbench/tb.sv
// Purpose: Self-checking bench of the reset control.
// Assumes: Extension shortened to four cycles.
// Notes: All accesses go through the host model.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int EXT = 4;
   logic clk = 0, srst = 1, analog_supply_ok = 0, core_supply_ok = 0, v;
   logic core_reset, soft_reset_active;
   logic [8:0] d;
   logic [63:0][8:0] reg_image;
   crc_pkg::crc_wr_s wr;
   crc_pkg::crc_rd_s rd;
   crc_pkg::crc_rdata_s rdata;
   int num_errors = 0, n_compared = 0, n;
   // Address, data written, data read back.
   logic [23:0] rows [4] = '{{6'h05, 9'h1AB, 9'h1AB}, {6'h3F, 9'h1FF, 9'h1FF},
      {6'h00, 9'h155, 9'h000}, {6'h01, 9'h001, 9'h001}};
   crc_codec_reset_control #(.EXT_CYCLES(EXT)) crc_codec_reset_control_i (.*);
   crc_host crc_host_i (.*);
   initial forever #50 clk = ~clk;
   task automatic cmp(input logic [579:0] g, e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t got %0h", $time, g);
      end
   endtask
   task automatic finish_test;
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Raise both supplies, count edges until release; a hang ends the run.
   task automatic power_up;
      n = 0;
      @(posedge clk) #1 {analog_supply_ok, core_supply_ok} = 2'b11;
      while (core_reset !== 1'b0 && n < 50) @(posedge clk) #1 n++;
      cmp(n, EXT + 1);
      if (n >= 50) finish_test;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 srst = 0;
      cmp({core_reset, soft_reset_active, reg_image}, {2'b10, 576'h0});
      crc_host_i.rd_t(6'h05, v, d);
      cmp(v, 1'b0);
      crc_host_i.wr_t(6'h05, 9'h1AB);
      @(posedge clk) #1 {analog_supply_ok, core_supply_ok} = 2'b11;
      repeat (2) @(posedge clk);
      #1 core_supply_ok = 0;
      power_up;
      crc_host_i.rd_t(6'h05, v, d);
      cmp({v, d}, {1'b1, 9'h000});
      for (int i = 0; i < 4; i++) begin
         crc_host_i.wr_t(rows[i][23:18], rows[i][17:9]);
         crc_host_i.rd_t(rows[i][23:18], v, d);
         cmp(d, rows[i][8:0]);
      end
      crc_host_i.wr_t(6'h02, 9'h0AA);
      crc_host_i.wr_t(6'h00, 9'h155);
      cmp({soft_reset_active, reg_image}, {1'b1, 576'h0});
      crc_host_i.wr_t(6'h03, 9'h003);
      cmp({soft_reset_active, reg_image[3], reg_image[2]}, {1'b0, 9'h003, 9'h000});
      analog_supply_ok = 0;
      @(posedge clk) #1 cmp({core_reset, reg_image}, {1'b1, 576'h0});
      finish_test;
   end
endmodule
`default_nettype wire
